// File: pkg/mzd_consts.svh
`ifndef MZD_CONSTS_SVH
`define MZD_CONSTS_SVH

// zone codes on the request port
`define MZD_ZONE_CFG 2'h0
`define MZD_ZONE_OTP 2'h1
`define MZD_ZONE_DATA 2'h2

// zone sizes in bytes
`define MZD_CFG_BYTES 11'h080
`define MZD_OTP_BYTES 11'h040

// field positions in the address word
`define MZD_OFS_LSB 0
`define MZD_OFS_MSB 2
`define MZD_SLOT_LSB 3
`define MZD_SLOT_MSB 6
`define MZD_BLK_LSB 8

// per-size limits
`define MZD_SMALL_LAST_SLOT 4'h7
`define MZD_BIG_SLOT 4'h8
`define MZD_BIG_LAST_BLK 4'hc
`define MZD_SMALL_LAST_BLK 4'h1
`define MZD_SMALL_LAST_BLK_WORDS 3'h0
`define MZD_MED_LAST_BLK 4'h2
`define MZD_MED_LAST_BLK_WORDS 3'h1

// fixed slot policy masks, bit n = slot n
`define MZD_WR_CLEAR_MASK 16'h0340
`define MZD_RD_CLEAR_MASK 16'h1d00

// status bytes
`define MZD_ST_OK 8'h00
`define MZD_ST_PARSE 8'h03
`define MZD_ST_EXEC 8'h0f

`endif

// File: pkg/mzd_pkg.sv
package mzd_pkg;

	typedef enum logic [1:0] {
		MZD_IDLE = 2'b00,
		MZD_DONE = 2'b01
	} mzd_state_t;

	typedef struct packed {
		mzd_state_t state;
		logic done;
		logic ok;
		logic [7:0] status;
		logic [10:0] byte_addr;
		logic [5:0] length;
		logic [3:0] slot;
	} mzd_regs_t;

endpackage : mzd_pkg

// File: rtl/mzd_slot_geom.sv
`timescale 1ns/1ps
`default_nettype none
`include "mzd_consts.svh"

// validity of block/word and block-bit width for one data slot
module mzd_slot_geom (
	input wire logic [3:0] slot, // slot number
	input wire logic [3:0] blk_raw, // address bits 11 to 8
	input wire logic [2:0] ofs, // word offset
	input wire logic is_block, // 32-byte access
	output logic [3:0] blk, // block with unused bits masked
	output logic valid // block and word exist in slot
);
	always_comb begin
		blk = 4'h0;
		valid = 1'b0;
		if (slot <= `MZD_SMALL_LAST_SLOT) begin
			blk = {3'h0, blk_raw[0]}; // [RULE_13]
			if (blk < `MZD_SMALL_LAST_BLK)
				valid = 1'b1;
			else
				valid = !is_block && (ofs <= `MZD_SMALL_LAST_BLK_WORDS); // [RULE_13]
		end else if (slot == `MZD_BIG_SLOT) begin
			blk = blk_raw; // [RULE_14]
			valid = (blk <= `MZD_BIG_LAST_BLK); // [RULE_14]
		end else begin
			blk = {2'h0, blk_raw[1:0]}; // [RULE_15]
			if (blk < `MZD_MED_LAST_BLK)
				valid = 1'b1;
			else if (blk == `MZD_MED_LAST_BLK)
				valid = !is_block && (ofs <= `MZD_MED_LAST_BLK_WORDS); // [RULE_15]
		end
	end
endmodule : mzd_slot_geom

`default_nettype wire

// File: rtl/mzd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mzd_consts.svh"

// Overview of operation
// (RULE_01) Configuration zone moves only 4-byte words or 32-byte blocks.
// (RULE_02) Configuration address uses bits 4:3 block, bits 2:0 word.
// (RULE_03) Configuration byte address is block*32 plus word*4, bytes 0 to 127.
// (RULE_04) Configuration and OTP zones accept reads only, never writes.
// (RULE_05) OTP zone is 64 bytes, accessed as words or blocks.
// (RULE_06) OTP address uses bit 3 block, bits 2:0 word.
// (RULE_07) Data zone has sixteen unequal slots, each with its own policy.
// (RULE_08) Clear-text writes allowed only to slots 6, 8 and 9.
// (RULE_09) Encrypted writes are refused for every slot.
// (RULE_10) Clear-text reads allowed only from slots 8, 10, 11, 12.
// (RULE_11) Slots not granted by the policy are refused both ways.
// (RULE_12) Data address: bits 6:3 slot, bits 2:0 word, bit 7 ignored.
// (RULE_13) Slots 0-7: 36 bytes, block bit 8, block 1 word 0 only.
// (RULE_14) Slot 8: 416 bytes, blocks 0 to 0xC from bits 11:8.
// (RULE_15) Slots 9-15: 72 bytes, block bits 9:8, block 2 words 0-1.
// (RULE_16) Refused by configuration or state answers status 0x0F.
// (RULE_17) Illegal parameters regardless of configuration answer status 0x03.
// (RULE_18) A 32-byte access ignores the word field and moves the block.
// (RULE_19) Invalid block, word or policy refusal: error status, no transfer.
module mzd_decoder
	import mzd_pkg::*;
(
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic req_valid, // one-cycle request strobe
	input wire logic [1:0] req_zone, // zone code
	input wire logic req_write, // 1 write, 0 read
	input wire logic req_encrypted, // write carries encrypted data
	input wire logic req_block, // 1 for 32 bytes, 0 for 4 bytes
	input wire logic [15:0] req_addr, // address word
	output logic rsp_valid, // one-cycle answer strobe
	output logic rsp_ok, // access granted, transfer may proceed
	output logic [7:0] rsp_status, // status byte
	output logic [3:0] rsp_slot, // decoded slot
	output logic [10:0] rsp_byte_addr, // first byte within zone or slot
	output logic [5:0] rsp_length // bytes to transfer, 0 on refusal
);
	mzd_regs_t r_q, r_d;

	logic [3:0] slot;
	logic [2:0] ofs;
	logic [3:0] dblk;
	logic dvalid;
	logic [10:0] ba;
	logic ok;
	logic [7:0] st;
	logic [15:0] wr_mask;
	logic [15:0] rd_mask;

	// policy masks held in nets so that a slot can index them
	assign wr_mask = `MZD_WR_CLEAR_MASK;
	assign rd_mask = `MZD_RD_CLEAR_MASK;
	assign slot = req_addr[`MZD_SLOT_MSB:`MZD_SLOT_LSB]; // [RULE_12]
	assign ofs = req_block ? 3'h0 : req_addr[`MZD_OFS_MSB:`MZD_OFS_LSB]; // [RULE_18]

	mzd_slot_geom u_geom (
		.slot(slot),
		.blk_raw(req_addr[11:8]),
		.ofs(ofs),
		.is_block(req_block),
		.blk(dblk),
		.valid(dvalid)
	);

	// ---------------------------------------------------------------
	// decode and policy
	// ---------------------------------------------------------------
	always_comb begin
		ba = 11'h000;
		ok = 1'b0;
		st = `MZD_ST_PARSE;
		case (req_zone)
			`MZD_ZONE_CFG: begin
				ba = {4'h0, req_addr[4:3], ofs, 2'h0}; // [RULE_02] [RULE_03] [RULE_01]
				ok = !req_write; // [RULE_04]
				st = req_write ? `MZD_ST_EXEC : `MZD_ST_OK;
			end
			`MZD_ZONE_OTP: begin
				ba = {5'h00, req_addr[3], ofs, 2'h0}; // [RULE_06] [RULE_05]
				ok = !req_write; // [RULE_04]
				st = req_write ? `MZD_ST_EXEC : `MZD_ST_OK;
			end
			`MZD_ZONE_DATA: begin
				ba = {2'h0, dblk, ofs, 2'h0};
				if (!dvalid) begin
					st = `MZD_ST_PARSE; // [RULE_17] [RULE_19]
				end else if (req_write) begin
					ok = !req_encrypted && wr_mask[slot]; // [RULE_08] [RULE_09] [RULE_07]
					st = ok ? `MZD_ST_OK : `MZD_ST_EXEC; // [RULE_11] [RULE_16]
				end else begin
					ok = rd_mask[slot]; // [RULE_10] [RULE_07]
					st = ok ? `MZD_ST_OK : `MZD_ST_EXEC; // [RULE_11] [RULE_16]
				end
			end
			default: begin
				st = `MZD_ST_PARSE; // [RULE_17]
			end
		endcase
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.state = MZD_IDLE;
		if (req_valid) begin
			r_d.state = MZD_DONE;
			r_d.done = 1'b1;
			r_d.ok = ok;
			r_d.status = st;
			r_d.byte_addr = ok ? ba : 11'h000;
			r_d.length = !ok ? 6'h00 : (req_block ? 6'h20 : 6'h04); // [RULE_19] [RULE_01]
			r_d.slot = (req_zone == `MZD_ZONE_DATA) ? slot : 4'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_q <= '{state: MZD_IDLE, done: 1'b0, ok: 1'b0, status: `MZD_ST_OK,
				byte_addr: 11'h000, length: 6'h00, slot: 4'h0};
		end else begin
			r_q <= r_d;
		end
	end

	assign rsp_valid = r_q.done;
	assign rsp_ok = r_q.ok;
	assign rsp_status = r_q.status;
	assign rsp_slot = r_q.slot;
	assign rsp_byte_addr = r_q.byte_addr;
	assign rsp_length = r_q.length;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_ro_zones;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_write && (req_zone != `MZD_ZONE_DATA) |=> rsp_valid && !rsp_ok;
	endproperty
	a_ro_zones: assert property (p_ro_zones) else $error("write to read-only zone granted"); // [RULE_04]

	property p_cfg_addr;
		@(posedge ref_clk) disable iff (rst)
		req_valid && !req_write && !req_block && req_zone == `MZD_ZONE_CFG
		|=> rsp_byte_addr == {4'h0, $past(req_addr[4:0]), 2'h0};
	endproperty
	a_cfg_addr: assert property (p_cfg_addr) else $error("config byte address wrong"); // [RULE_03]

	property p_otp_addr;
		@(posedge ref_clk) disable iff (rst)
		req_valid && !req_write && !req_block && req_zone == `MZD_ZONE_OTP
		|=> rsp_byte_addr == {5'h00, $past(req_addr[3:0]), 2'h0} && rsp_byte_addr < `MZD_OTP_BYTES;
	endproperty
	a_otp_addr: assert property (p_otp_addr) else $error("otp byte address wrong"); // [RULE_06]

	property p_enc_wr;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_write && req_encrypted |=> !rsp_ok && rsp_length == 6'h00;
	endproperty
	a_enc_wr: assert property (p_enc_wr) else $error("encrypted write granted"); // [RULE_09]

	property p_wr_policy;
		@(posedge ref_clk) disable iff (rst)
		rsp_valid && rsp_ok && $past(req_write) |-> rsp_slot inside {4'h6, 4'h8, 4'h9};
	endproperty
	a_wr_policy: assert property (p_wr_policy) else $error("write granted to locked slot"); // [RULE_08]

	property p_rd_policy;
		@(posedge ref_clk) disable iff (rst)
		rsp_valid && rsp_ok && !$past(req_write) && $past(req_zone) == `MZD_ZONE_DATA
		|-> rsp_slot inside {4'h8, 4'ha, 4'hb, 4'hc};
	endproperty
	a_rd_policy: assert property (p_rd_policy) else $error("read granted from locked slot"); // [RULE_10]

	property p_big_blk;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_zone == `MZD_ZONE_DATA && req_addr[6:3] == 4'h8 && req_addr[11:8] > 4'hc
		|=> !rsp_ok && rsp_status == `MZD_ST_PARSE;
	endproperty
	a_big_blk: assert property (p_big_blk) else $error("slot 8 block past end accepted"); // [RULE_14]

	property p_blk_len;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_block |=> rsp_length == (rsp_ok ? 6'h20 : 6'h00) && rsp_byte_addr[4:0] == 5'h00;
	endproperty
	a_blk_len: assert property (p_blk_len) else $error("block access not aligned or sized"); // [RULE_18]

	property p_refuse;
		@(posedge ref_clk) disable iff (rst)
		rsp_valid && !rsp_ok |-> rsp_length == 6'h00 && rsp_status != `MZD_ST_OK;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refusal without error status"); // [RULE_19]

	property p_bad_zone;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_zone == 2'h3 |=> rsp_valid && !rsp_ok && rsp_status == `MZD_ST_PARSE;
	endproperty
	a_bad_zone: assert property (p_bad_zone) else $error("illegal zone not refused"); // [RULE_17]

	property p_small_tail;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_zone == `MZD_ZONE_DATA && req_addr[6:3] <= 4'h7 && req_addr[8]
		&& (req_block || req_addr[2:0] != 3'h0) |=> !rsp_ok && rsp_status == `MZD_ST_PARSE;
	endproperty
	a_small_tail: assert property (p_small_tail) else $error("small slot tail accepted"); // [RULE_13]

	property p_med_tail;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_zone == `MZD_ZONE_DATA && req_addr[6:3] >= 4'h9
		&& (req_addr[9:8] == 2'h3
		|| (req_addr[9:8] == 2'h2 && (req_block || req_addr[2:0] > 3'h1)))
		|=> !rsp_ok && rsp_status == `MZD_ST_PARSE;
	endproperty
	a_med_tail: assert property (p_med_tail) else $error("medium slot tail accepted"); // [RULE_15]

	property p_rd_refuse;
		@(posedge ref_clk) disable iff (rst)
		req_valid && req_zone == `MZD_ZONE_DATA && !req_write
		&& !(req_addr[6:3] inside {4'h8, 4'ha, 4'hb, 4'hc}) |=> !rsp_ok && rsp_length == 6'h00;
	endproperty
	a_rd_refuse: assert property (p_rd_refuse) else $error("read of locked slot granted"); // [RULE_11]
endmodule : mzd_decoder

`default_nettype wire

// File: tb/mzd_host.sv
`timescale 1ns/1ps
`default_nettype none

// host side: issues requests, scrambles fields when idle
module mzd_host (
	input wire logic ref_clk, // clock
	output logic req_valid, // request strobe
	output logic [1:0] req_zone, // zone code
	output logic req_write, // write flag
	output logic req_encrypted, // encrypted flag
	output logic req_block, // 32-byte flag
	output logic [15:0] req_addr // address word
);
	initial begin
		req_valid = 1'b0;
		req_zone = 2'h0;
		req_write = 1'b0;
		req_encrypted = 1'b0;
		req_block = 1'b0;
		req_addr = 16'h0000;
	end

	task automatic issue(input logic [1:0] z, input logic w, e, b, input logic [15:0] a);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_zone <= z;
		req_write <= w;
		req_encrypted <= e;
		req_block <= b; // only whole words or blocks
		req_addr <= a;
	endtask : issue

	task automatic idle;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		req_addr <= ~req_addr;
		req_zone <= ~req_zone;
	endtask : idle
endmodule : mzd_host

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid, req_write, req_encrypted, req_block, rsp_valid, rsp_ok;
	logic [1:0] req_zone;
	logic [15:0] req_addr;
	logic [7:0] rsp_status;
	logic [3:0] rsp_slot;
	logic [10:0] rsp_byte_addr;
	logic [5:0] rsp_length;
	logic [29:0] exp_q[$];
	logic [31:0] r;
	logic [15:0] dir_addr[12] = '{16'h0150, 16'h0c47, 16'h0d40, 16'h0100, 16'h0101, 16'h0249,
		16'h024a, 16'h0330, 16'h01b0, 16'h0258, 16'h0cd8, 16'h0360};
	int num_errors = 0;
	int check_count = 0;
	int seed = 36216;

	always #2.5 ref_clk = ~ref_clk;

	mzd_host host (.ref_clk(ref_clk), .req_valid(req_valid), .req_zone(req_zone),
		.req_write(req_write), .req_encrypted(req_encrypted), .req_block(req_block),
		.req_addr(req_addr));

	mzd_decoder dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_zone(req_zone),
		.req_write(req_write), .req_encrypted(req_encrypted), .req_block(req_block),
		.req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_status(rsp_status),
		.rsp_slot(rsp_slot), .rsp_byte_addr(rsp_byte_addr), .rsp_length(rsp_length));

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic logic [29:0] model(int z, w, e, b, a);
		int s, blk, ofs, ok, st, ba;
		s = 0;
		blk = 0;
		st = 0;
		ofs = a & 7;
		if (z == 0) blk = (a >> 3) & 3;
		else if (z == 1) blk = (a >> 3) & 1;
		else if (z == 3) st = 3;
		else begin
			s = (a >> 3) & 15;
			if (s < 8) begin
				blk = (a >> 8) & 1;
				if (blk == 1 && (b || ofs != 0)) st = 3;
			end else if (s == 8) begin
				blk = (a >> 8) & 15;
				if (blk > 12) st = 3;
			end else begin
				blk = (a >> 8) & 3;
				if (blk == 3 || (blk == 2 && (b || ofs > 1))) st = 3;
			end
			if (st == 0 && (w ? (e || !(s == 6 || s == 8 || s == 9))
				: !(s == 8 || (s >= 10 && s <= 12)))) st = 15;
		end
		if (z < 2 && w) st = 15;
		ok = (st == 0);
		ba = ok ? blk * 32 + (b ? 0 : ofs * 4) : 0;
		return {ok[0], st[7:0], s[3:0], ba[10:0], ok ? (b ? 6'h20 : 6'h04) : 6'h00};
	endfunction : model

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic chk_rsp(input logic [29:0] got, input logic [29:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_rsp

	task automatic go(input logic [1:0] z, input logic w, e, b, input logic [15:0] a);
		host.issue(z, w, e, b, a);
		exp_q.push_back(model(z, w, e, b, a));
	endtask : go

	always @(negedge ref_clk) begin
		if (!rst && rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk_rsp(30'h0, 30'h1);
			else chk_rsp({rsp_ok, rsp_status, rsp_slot, rsp_byte_addr, rsp_length},
				exp_q.pop_front());
		end
	end

	task automatic summarize;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	initial begin
		#20000;
		num_errors++;
		summarize();
	end

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk_rsp({rsp_ok, rsp_status, rsp_slot, rsp_byte_addr, rsp_length}, 30'h0);
		go(2'h0, 1'b0, 1'b0, 1'b0, 16'hffff);
		go(2'h1, 1'b0, 1'b0, 1'b1, 16'h000f);
		go(2'h0, 1'b1, 1'b0, 1'b0, 16'h0000);
		go(2'h1, 1'b1, 1'b0, 1'b1, 16'h0008);
		go(2'h3, 1'b0, 1'b0, 1'b0, 16'h0000);
		foreach (dir_addr[i])
			for (int k = 0; k < 8; k++) go(2'h2, k[2], k[1], k[0], dir_addr[i]);
		$display("test directed done");
		for (int i = 0; i < 400; i++) begin
			r = $random(seed);
			go(r[1:0], r[2], r[3], r[4], r[31:16]);
		end
		host.idle();
		repeat (4) @(posedge ref_clk);
		chk_rsp(30'(exp_q.size()), 30'h0);
		$display("test random done");
		summarize();
	end
endmodule : testbench

`default_nettype wire
